//--- verilog/dsr_state_reg.sv
`timescale 1ns/1ps
module dsr_state_reg
(
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    rst_b,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [dsr_pkg::ADDR_W-1:0] paddr,
	input  wire logic [dsr_pkg::DATA_W-1:0] pwdata,
	output logic      [dsr_pkg::DATA_W-1:0] prdata,
	output logic                         pready,
	output logic                         pslverr,
	// FIFO fill level, same clock
	input  wire logic [dsr_pkg::FCOUNT_W-1:0] fifo_count,
	// Arithmetic path
	input  wire dsr_pkg::dsr_alu_req_t   alu_req,
	output logic      [dsr_pkg::DATA_W-1:0] alu_result,
	output logic                         alu_done,
	output logic                         arith_overflow,
	// Address generators
	input  wire dsr_pkg::dsr_agen_req_t  x_agen_req,
	input  wire dsr_pkg::dsr_agen_req_t  y_agen_req,
	output logic      [dsr_pkg::AGEN_W-1:0] x_data_memory_addr,
	output logic      [dsr_pkg::AGEN_W-1:0] y_data_memory_addr,
	// Interrupt request pins
	input  wire logic                    interrupt_request_0,
	input  wire logic                    interrupt_request_1,
	input  wire logic                    interrupt_request_2,
	output logic      [dsr_pkg::IRQ_N-1:0] irq_accept,
	// Machine clock and event interrupt
	output logic                         machine_clock_output,
	output logic                         event_irq
);
	import dsr_pkg::*;

	// Lane adder: returns {overflow, sum}
	function automatic logic [LANE_W:0] lane_add
	(
		input logic [LANE_W-1:0] a,
		input logic [LANE_W-1:0] b,
		input logic              sub
	);
		// Operand after optional inversion, and raw sum
		logic [LANE_W-1:0] bb;
		logic [LANE_W-1:0] s;
		bb = sub ? ~b : b;
		s  = a + bb + {{(LANE_W-1){1'b0}}, sub};
		// Sign of result disagrees with like-signed operands
		lane_add = {(a[LANE_W-1] == bb[LANE_W-1])
			&& (s[LANE_W-1] != a[LANE_W-1]), s};
	endfunction

	// Lane clamp on overflow
	function automatic logic [LANE_W-1:0] lane_sat
	(
		input logic [LANE_W:0]   r,
		input logic [LANE_W-1:0] a,
		input logic              en
	);
		if (en && r[LANE_W])
			// Direction follows the sign of the first operand
			lane_sat = a[LANE_W-1] ? SAT_NEG : SAT_POS;
		else
			lane_sat = r[LANE_W-1:0];
	endfunction

	// Next address, wrapping inside a modulo window when enabled
	function automatic logic [AGEN_W-1:0] agen_next
	(
		input dsr_agen_req_t r,
		input logic          circ
	);
		// Extra bit keeps the wrap compare free of carry loss
		logic [AGEN_W:0] n;
		n = {1'b0, r.cur} + {1'b0, r.step};
		if (circ && (n >= ({1'b0, r.base} + {1'b0, r.len})))
			agen_next = AGEN_W'(n - {1'b0, r.len});
		else
			agen_next = n[AGEN_W-1:0];
	endfunction

	// Machine clock divider state
	logic                 mc_phase;    // Divider phase
	logic                 mc_en;       // One-cycle machine cycle enable

	// Processor state fields
	logic                 gate;        // Interrupt gate
	logic                 ycirc;       // Y memory circular
	logic                 xcirc;       // X memory circular
	logic [1:0]           mode;        // Operating mode
	logic                 saturate_enable;         // Saturate enable
	logic                 fifo_empty_flag; // Empty flag

	// Event registers
	logic [EVT_W-1:0]     evt_status;  // Sticky events
	logic [EVT_W-1:0]     evt_enable;  // Event mask
	logic [EVT_W-1:0]     evt_set;     // Events this cycle
	logic [EVT_W-1:0]     evt_clr;     // Clear strobes

	// Interrupt pin synchronisers
	logic [IRQ_N-1:0]     irq_meta;    // First stage only
	logic [IRQ_N-1:0]     irq_sync;    // Usable level

	// Bus decode
	wire                  acc      = psel & penable;
	wire                  wr_en    = acc & pwrite;
	wire                  hit_st   = (paddr == OFS_STATE);
	wire                  hit_es   = (paddr == OFS_EVT_ST);
	wire                  hit_ec   = (paddr == OFS_EVT_CL);
	wire                  hit_ee   = (paddr == OFS_EVT_EN);
	wire                  hit_rs   = (paddr == OFS_RESULT);
	wire                  hit_any  = hit_st | hit_es | hit_ec | hit_ee
		| hit_rs;
	wire                  wr_state = wr_en & hit_st;
	wire                  wr_en_r  = wr_en & hit_ee;
	wire                  wr_clr   = wr_en & hit_ec;

	// Written mode, undefined code folded to real
	// Other fields of the same write still land normally
	wire [1:0]            wr_mode  = pwdata[BIT_MODE+:2];
	wire [1:0]            next_mode = (wr_mode == MODE_UNDEF)
		? MODE_REAL : wr_mode;

	// Packed state image
	wire [STATE_W-1:0]    state_img = {1'b0, fifo_empty_flag, saturate_enable,
		mode, xcirc, ycirc, gate};

	// Mode decode
	wire                  is_double  = (mode == MODE_DOUBLE);
	wire                  is_complex = (mode == MODE_COMPLEX);

	// Saturation allowed only outside double precision
	wire                  sat_on = saturate_enable & ~is_double;

	// Lane results
	// Low lane holds real data, high lane the imaginary part
	wire [LANE_W:0]       lo_r = lane_add(alu_req.a[LANE_W-1:0],
		alu_req.b[LANE_W-1:0], alu_req.sub);
	wire [LANE_W:0]       hi_r = lane_add(alu_req.a[DATA_W-1:LANE_W],
		alu_req.b[DATA_W-1:LANE_W], alu_req.sub);

	// Full width double precision sum
	wire [DATA_W-1:0]     dbl_b   = alu_req.sub ? ~alu_req.b : alu_req.b;
	wire [DATA_W-1:0]     dbl_sum = alu_req.a + dbl_b
		+ {{(DATA_W-1){1'b0}}, alu_req.sub};
	wire                  dbl_ovf = (alu_req.a[DATA_W-1] == dbl_b[DATA_W-1])
		&& (dbl_sum[DATA_W-1] != alu_req.a[DATA_W-1]);

	// Per-mode result and overflow selection
	wire [LANE_W-1:0]     lo_out = lane_sat(lo_r, alu_req.a[LANE_W-1:0],
		sat_on);
	wire [LANE_W-1:0]     hi_out = lane_sat(hi_r,
		alu_req.a[DATA_W-1:LANE_W], sat_on);
	wire [DATA_W-1:0]     next_result = is_double ? dbl_sum
		: is_complex ? {hi_out, lo_out}
		: {{LANE_W{lo_out[LANE_W-1]}}, lo_out};
	wire                  next_ovf = is_double ? dbl_ovf
		: is_complex ? (lo_r[LANE_W] | hi_r[LANE_W])
		: lo_r[LANE_W];

	// Interrupt acceptance, gated by the state bit
	wire [IRQ_N-1:0]      next_accept = (gate && mc_en)
		? irq_sync : {IRQ_N{1'b0}};

	// Read data mux
	wire [DATA_W-1:0]     rd_mux =
		hit_st ? {{(DATA_W-STATE_W){1'b0}}, state_img}
		: hit_es ? {{(DATA_W-EVT_W){1'b0}}, evt_status}
		: hit_ee ? {{(DATA_W-EVT_W){1'b0}}, evt_enable}
		: hit_rs ? alu_result
		: {DATA_W{1'b0}};

	// Event sources
	// Empty event marks the step into empty, not the level
	assign evt_set[EVT_OVF]   = mc_en & alu_req.valid & next_ovf;
	assign evt_set[EVT_EMPTY] = (fifo_count == '0) & ~fifo_empty_flag;
	assign evt_set[EVT_IRQ]   = |next_accept;
	// Write one to clear; a set in the same cycle still wins
	assign evt_clr = wr_clr ? pwdata[EVT_W-1:0] : {EVT_W{1'b0}};

	// Zero wait state slave
	assign pready  = 1'b1;
	assign pslverr = acc & ~hit_any;

	// Level interrupt from enabled sticky events
	assign event_irq = |(evt_status & evt_enable);

	// Machine cycle enable every second reference edge
	assign mc_en = mc_phase;

	// Divider toggles; output runs at half reference rate
	// Output equals the phase, so the enable cycle sees it high
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			mc_phase             <= 1'b0;
			machine_clock_output <= 1'b0;
		end
		else
		begin
			mc_phase             <= ~mc_phase;
			machine_clock_output <= ~mc_phase;
		end
	end

	// Software-visible state bits
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			gate  <= 1'b0;
			ycirc <= 1'b0;
			xcirc <= 1'b0;
			mode  <= RST_MODE;
			saturate_enable   <= 1'b0;
		end
		else if (wr_state)
		begin
			gate  <= pwdata[BIT_GATE];
			ycirc <= pwdata[BIT_YCIRC];
			xcirc <= pwdata[BIT_XCIRC];
			mode  <= next_mode;
			saturate_enable   <= pwdata[BIT_SAT];
		end
	end

	// Empty flag follows the FIFO level
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			fifo_empty_flag <= 1'b1;
		else
			fifo_empty_flag <= (fifo_count == '0);
	end

	// Sticky events, set beats clear
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			evt_status <= RST_EVT;
		else
			evt_status <= (evt_status & ~evt_clr) | evt_set;
	end

	// Event mask
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			evt_enable <= RST_EVT;
		else if (wr_en_r)
			evt_enable <= pwdata[EVT_W-1:0];
	end

	// Two-stage synchronisers for request pins
	// Only the second stage feeds logic; the first may go metastable
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			irq_meta <= '0;
			irq_sync <= '0;
		end
		else
		begin
			irq_meta <= {interrupt_request_2, interrupt_request_1,
				interrupt_request_0};
			irq_sync <= irq_meta;
		end
	end

	// Accepted requests, one pulse per machine cycle
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			irq_accept <= '0;
		else
			irq_accept <= next_accept;
	end

	// Arithmetic result, taken once per machine cycle
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			alu_result     <= '0;
			arith_overflow <= 1'b0;
			alu_done       <= 1'b0;
		end
		else
		begin
			alu_done <= mc_en & alu_req.valid;
			if (mc_en && alu_req.valid)
			begin
				alu_result     <= next_result;
				arith_overflow <= next_ovf;
			end
		end
	end

	// X and Y address generators
	// Wrap keeps each pointer inside its modulo window
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			x_data_memory_addr <= '0;
			y_data_memory_addr <= '0;
		end
		else if (mc_en)
		begin
			if (x_agen_req.valid)
				x_data_memory_addr <= agen_next(x_agen_req, xcirc);
			if (y_agen_req.valid)
				y_data_memory_addr <= agen_next(y_agen_req, ycirc);
		end
	end

	// Registered read data
	// Captured in the setup cycle, so a read shows that cycle's state
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			prdata <= '0;
		else if (psel && !penable && !pwrite)
			prdata <= rd_mux;
	end

endmodule

//--- verilog/dsr_pkg.sv
package dsr_pkg;

	// Bus and data widths
	localparam int ADDR_W   = 12;
	localparam int DATA_W   = 32;
	localparam int STATE_W  = 8;
	localparam int LANE_W   = 16;
	localparam int AGEN_W   = 16;
	localparam int FCOUNT_W = 5;
	localparam int EVT_W    = 3;
	localparam int IRQ_N    = 3;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_STATE  = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_EVT_ST = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_EVT_CL = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_EVT_EN = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_RESULT = 12'h010;

	// Processor state field positions
	localparam int BIT_GATE  = 0;
	localparam int BIT_YCIRC = 1;
	localparam int BIT_XCIRC = 2;
	localparam int BIT_MODE  = 3;
	localparam int BIT_SAT   = 5;
	localparam int BIT_EMPTY = 6;

	// Event status bit positions
	localparam int EVT_OVF   = 0;
	localparam int EVT_EMPTY = 1;
	localparam int EVT_IRQ   = 2;

	// Operating mode codes
	localparam logic [1:0] MODE_UNDEF   = 2'h0;
	localparam logic [1:0] MODE_REAL    = 2'h1;
	localparam logic [1:0] MODE_DOUBLE  = 2'h2;
	localparam logic [1:0] MODE_COMPLEX = 2'h3;

	// Saturation limits
	localparam logic [LANE_W-1:0] SAT_POS = 16'h7FFF;
	localparam logic [LANE_W-1:0] SAT_NEG = 16'h8000;

	// Reset values
	localparam logic [1:0]       RST_MODE = MODE_REAL;
	localparam logic [EVT_W-1:0] RST_EVT  = 3'h0;

	// Clock division: machine cycle is two reference periods
	localparam int CLK_DIV = 2;

	// Arithmetic request
	typedef struct packed {
		logic              valid;
		logic              sub;
		logic [DATA_W-1:0] a;
		logic [DATA_W-1:0] b;
	} dsr_alu_req_t;

	// Address generation request
	typedef struct packed {
		logic              valid;
		logic [AGEN_W-1:0] cur;
		logic [AGEN_W-1:0] step;
		logic [AGEN_W-1:0] base;
		logic [AGEN_W-1:0] len;
	} dsr_agen_req_t;

endpackage

//--- sim/dsr_state_reg_asserts.sv
`timescale 1ns/1ps
module dsr_state_reg_chk
(
	// Clock, reset and bus
	input wire logic                          ref_clk,
	input wire logic                          rst_b,
	input wire logic                          psel,
	input wire logic                          penable,
	input wire logic                          pwrite,
	input wire logic [dsr_pkg::ADDR_W-1:0]    paddr,
	input wire logic [dsr_pkg::DATA_W-1:0]    prdata,
	// Watched pins
	input wire logic [dsr_pkg::FCOUNT_W-1:0]  fifo_count,
	input wire logic                          alu_done,
	input wire logic                          arith_overflow,
	input wire logic [dsr_pkg::AGEN_W-1:0]    x_data_memory_addr,
	input wire logic [dsr_pkg::AGEN_W-1:0]    y_data_memory_addr,
	input wire logic [dsr_pkg::IRQ_N-1:0]     irq_accept,
	input wire logic                          machine_clock_output
);
	import dsr_pkg::*;
	// One clock domain, reset masks all checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	// Machine clock flips on every reference edge
	a_mclk_toggle: assert property ($past(rst_b) |->
		machine_clock_output != $past(machine_clock_output))
		else $error("machine clock stalled");
	// Results land in the cycle after a machine cycle edge
	a_done_phase: assert property (alu_done |->
		!machine_clock_output)
		else $error("result outside machine phase");
	a_done_pulse: assert property (alu_done |=> !alu_done)
		else $error("done longer than one cycle");
	// Accepted requests pulse once per machine cycle
	a_accept_phase: assert property (|irq_accept |->
		!machine_clock_output)
		else $error("accept outside machine phase");
	a_accept_pulse: assert property (|irq_accept |=> irq_accept == 3'h0)
		else $error("accept longer than one cycle");
	// Overflow moves only with a finished operation
	a_ovf_hold: assert property ($past(rst_b) && !alu_done |->
		$stable(arith_overflow))
		else $error("overflow changed without result");
	// Address generators step on machine cycles only
	a_xaddr_phase: assert property ($past(rst_b) &&
		x_data_memory_addr != $past(x_data_memory_addr) |->
		!machine_clock_output)
		else $error("x address moved off phase");
	a_yaddr_phase: assert property ($past(rst_b) &&
		y_data_memory_addr != $past(y_data_memory_addr) |->
		!machine_clock_output)
		else $error("y address moved off phase");
	// Empty flag read back matches the fill level
	a_empty_read: assert property ($past(rst_b) && psel && !penable &&
		!pwrite && paddr == OFS_STATE && $stable(fifo_count) |=>
		prdata[BIT_EMPTY] == ($past(fifo_count) == 5'h00))
		else $error("empty flag wrong");
endmodule

//--- sim/dsr_state_reg_tb_top.sv
`timescale 1ns/1ps
module dsr_state_reg_tb_top;
	import dsr_pkg::*;
	// Bench driven inputs
	logic                ref_clk = 1'b0;
	logic                rst_b = 1'b0;
	logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0]   paddr = 12'h000;
	logic [DATA_W-1:0]   pwdata = 32'h0;
	logic [FCOUNT_W-1:0] fifo_count = 5'h00;
	dsr_alu_req_t        alu_req = '0;
	dsr_agen_req_t       x_req = '0, y_req = '0;
	logic [2:0]          pin = 3'h0;
	// Observed outputs and bench state
	logic [DATA_W-1:0]   prdata, alu_result, rd;
	logic                pready, pslverr, perr, alu_done, ovf, mco, eirq;
	logic [AGEN_W-1:0]   x_addr, y_addr;
	logic [2:0]          acc, acc_seen = 3'h0;
	int                  err_total = 0, checks = 0, cyc = 0;
	// Reference clock, 8 ns
	always #4 ref_clk = ~ref_clk;
	dsr_state_reg dsr_state_reg_inst (.ref_clk, .rst_b, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fifo_count,
		.alu_req, .alu_result, .alu_done, .arith_overflow(ovf),
		.x_agen_req(x_req), .y_agen_req(y_req), .x_data_memory_addr(x_addr),
		.y_data_memory_addr(y_addr), .interrupt_request_0(pin[0]),
		.interrupt_request_1(pin[1]), .interrupt_request_2(pin[2]),
		.irq_accept(acc), .machine_clock_output(mco), .event_irq(eirq));
	// Hang guard and accept recorder
	always @(posedge ref_clk)
	begin
		if (rst_b)
			acc_seen <= acc_seen | acc;
		cyc++;
		if (cyc == 2000)
		begin
			err_total++;
			finish_test;
		end
	end
	// Compare and count
	task automatic chk(input string n, input logic [31:0] e, s);
		checks++;
		if (s !== e)
		begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	// One APB transfer, entered just after an edge
	task automatic apb(input logic w, input logic [11:0] a, input int d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1)
			@(posedge ref_clk);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	// Arithmetic request held over one full machine cycle
	task automatic alu(input logic s, input logic [31:0] a, b, e, input o);
		alu_req <= '{1'b1, s, a, b};
		repeat (2) @(posedge ref_clk);
		alu_req.valid <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk("alu result", e, alu_result);
		chk("overflow", o, ovf);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		apb(0, OFS_STATE, 0);
		chk("state reset", 32'h48, rd);
		fifo_count <= 5'h03;
		for (int m = 0; m < 4; m++)
		begin
			apb(1, OFS_STATE, 32'h67 | (m << 3));
			apb(0, OFS_STATE, 0);
			chk("mode", 32'h27 | ((m == 0 ? 1 : m) << 3), rd);
		end
		$display("test state done");
		apb(1, OFS_STATE, 32'h28);
		alu(0, 32'h7000, 32'h7000, 32'h7FFF, 1);
		alu(0, 32'h9000, 32'h9000, 32'hFFFF8000, 1);
		apb(1, OFS_STATE, 32'h38);
		alu(0, 32'h17000, 32'h27000, 32'h37FFF, 1);
		apb(1, OFS_STATE, 32'h30);
		alu(0, 32'h7FFFFFFF, 32'h1, 32'h80000000, 1);
		apb(1, OFS_STATE, 32'h08);
		alu(1, 32'h7000, 32'hA000, 32'hFFFFD000, 1);
		alu(0, 32'h1, 32'h2, 32'h3, 0);
		$display("test alu done");
		for (int c = 0; c < 2; c++)
		begin
			apb(1, OFS_STATE, c ? 32'h0A : 32'h0C);
			x_req <= '{1'b1, 16'h0005, 16'h0004, 16'h0000, 16'h0008};
			y_req <= '{1'b1, 16'h0005, 16'h0004, 16'h0000, 16'h0008};
			repeat (2) @(posedge ref_clk);
			x_req.valid <= 1'b0;
			y_req.valid <= 1'b0;
			repeat (2) @(posedge ref_clk);
			chk("x addr", c ? 9 : 1, x_addr);
			chk("y addr", c ? 1 : 9, y_addr);
		end
		$display("test circular done");
		apb(1, OFS_EVT_CL, 7);
		pin <= 3'h7;
		repeat (8) @(posedge ref_clk);
		apb(0, OFS_EVT_ST, 0);
		chk("gated status", 0, rd);
		chk("gated accepts", 0, acc_seen);
		apb(1, OFS_STATE, 32'h09);
		repeat (8) @(posedge ref_clk);
		pin <= 3'h0;
		fifo_count <= 5'h00;
		repeat (4) @(posedge ref_clk);
		chk("accepts", 7, acc_seen);
		apb(0, OFS_STATE, 0);
		chk("empty again", 32'h49, rd);
		apb(0, OFS_EVT_ST, 0);
		chk("status", 6, rd);
		apb(1, OFS_EVT_EN, 4);
		chk("irq raised", 1, eirq);
		apb(1, OFS_EVT_EN, 0);
		chk("irq masked", 0, eirq);
		apb(1, OFS_EVT_EN, 4);
		apb(1, OFS_EVT_CL, 6);
		chk("irq cleared", 0, eirq);
		apb(0, 12'h020, 0);
		chk("unmapped err", 1, perr);
		chk("unmapped data", 0, rd);
		$display("test interrupt done");
		finish_test;
	end
endmodule
bind dsr_state_reg dsr_state_reg_chk dsr_state_reg_chk_inst (.ref_clk, .rst_b,
	.psel, .penable, .pwrite, .paddr, .prdata, .fifo_count, .alu_done,
	.arith_overflow, .x_data_memory_addr, .y_data_memory_addr, .irq_accept,
	.machine_clock_output);
